// File: hdl/apc_command_port.sv
// command port, phrase pointer fetch, voice data sequencer and mixer
`timescale 1ns/1ps
module apc_command_port
  import apc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] command_bus_in,
  output logic [3:0] command_bus_out,
  output logic [3:0] command_bus_oe,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic chip_select_n,
  output logic [ADDR_W-1:0] rom_address_out,
  input wire logic [7:0] rom_data_in,
  output logic [11:0] voice_sample_out,
  output logic [3:0] channel_busy
);
  typedef struct packed {
    logic wr_q;
    logic second;
    logic [6:0] first_lo;
    logic ptr_pend;
    logic [1:0] ptr_ch;
    logic [PHRASE_W-1:0] ptr_phrase;
    logic [3:0] ptr_atten;
    logic [2:0] ptr_idx;
    logic [39:0] ptr_sh;
    apc_state_t st;
    logic [3:0] wait_cnt;
    logic [1:0] svc_ch;
    logic [7:0] div_cnt;
    logic tick_pend;
    logic [3:0] busy;
    logic [3:0][ADDR_W-1:0] cur;
    logic [3:0][ADDR_W-1:0] stp;
    logic [3:0] lo;
    logic [3:0][3:0] hold;
    logic [3:0][3:0] atten;
    logic [ADDR_W-1:0] rom_addr;
    logic [3:0] step;
    logic [3:0] clr;
    logic [3:0] nib;
    logic [3:0] oe;
    logic [3:0] rdat;
    logic [11:0] mix;
  } apc_port_st_t;

  apc_port_st_t r;
  apc_port_st_t n;
  logic [3:0][11:0] voice_out;

  for (genvar g = 0; g < 4; g++)
  begin : g_voice
    apc_voice u_voice (
      .clk(clk),
      .nrst(nrst),
      .clear(r.clr[g]),
      .step(r.step[g]),
      .nibble(r.nib),
      .atten(r.atten[g]),
      .sample_out(voice_out[g])
    );
  end

  always_comb
  begin
    logic wr_rise;
    logic adv;
    logic [PHRASE_W-1:0] phrase;
    logic [47:0] entry;
    logic signed [13:0] acc;
    wr_rise = !r.wr_q && write_strobe_n && !chip_select_n;
    adv = 1'b0;
    phrase = {command_bus_in[7:EXT_LSB], r.first_lo};
    entry = {r.ptr_sh, rom_data_in};
    acc = 14'sh0;
    n = r;
    n.wr_q = write_strobe_n;
    n.step = 4'h0;
    n.clr = 4'h0;
    // read drive is one cycle behind the strobes, lines float otherwise
    n.oe = {4{!chip_select_n && !read_strobe_n}};
    n.rdat = r.busy;

    // sample clock; a late service round keeps the tick pending
    if (r.div_cnt == 8'h00)
    begin
      n.div_cnt = SAMPLE_DIV_M1;
      for (int c = 0; c < 4; c++)
        acc = acc + $signed({{2{voice_out[c][11]}}, voice_out[c]});
      n.mix = 12'(acc >>> 2) + MIX_OFFSET;
    end
    else
      n.div_cnt = r.div_cnt - 8'h01;

    case (r.st)
      ST_IDLE:
      begin
        if (r.tick_pend)
        begin
          n.svc_ch = 2'h0;
          n.st = ST_SVC;
        end
        else if (r.ptr_pend)
        begin
          n.rom_addr = ADDR_W'(r.ptr_phrase) << ENTRY_SHIFT;
          n.ptr_idx = 3'h0;
          n.wait_cnt = ROM_WAIT;
          n.st = ST_PTR;
        end
      end
      ST_PTR:
      begin
        if (r.wait_cnt != 4'h0)
          n.wait_cnt = r.wait_cnt - 4'h1;
        else if (r.ptr_idx == PTR_LAST_IDX)
        begin
          // two unused bytes of the entry are never read
          n.cur[r.ptr_ch] = entry[47:24];
          n.stp[r.ptr_ch] = entry[23:0];
          n.busy[r.ptr_ch] = 1'b1;
          n.lo[r.ptr_ch] = 1'b0;
          n.atten[r.ptr_ch] = (r.ptr_atten > ATTEN_MAX) ? ATTEN_MAX : r.ptr_atten;
          n.clr[r.ptr_ch] = 1'b1;
          n.ptr_pend = 1'b0;
          n.st = ST_IDLE;
        end
        else
        begin
          n.ptr_sh = entry[39:0];
          n.ptr_idx = r.ptr_idx + 3'h1;
          n.rom_addr = r.rom_addr + 24'h000001;
          n.wait_cnt = ROM_WAIT;
        end
      end
      ST_SVC:
      begin
        if (!r.busy[r.svc_ch])
          adv = 1'b1;
        else if (!r.lo[r.svc_ch])
        begin
          n.rom_addr = r.cur[r.svc_ch];
          n.wait_cnt = ROM_WAIT;
          n.st = ST_FETCH;
        end
        else
        begin
          n.nib = r.hold[r.svc_ch];
          n.step[r.svc_ch] = 1'b1;
          n.lo[r.svc_ch] = 1'b0;
          n.cur[r.svc_ch] = r.cur[r.svc_ch] + 24'h000001;
          if (r.cur[r.svc_ch] == r.stp[r.svc_ch])
            n.busy[r.svc_ch] = 1'b0;
          adv = 1'b1;
        end
      end
      ST_FETCH:
      begin
        if (r.wait_cnt != 4'h0)
          n.wait_cnt = r.wait_cnt - 4'h1;
        else
        begin
          // high nibble plays first, low nibble on the next sample
          n.nib = rom_data_in[7:4];
          n.hold[r.svc_ch] = rom_data_in[3:0];
          n.step[r.svc_ch] = 1'b1;
          n.lo[r.svc_ch] = 1'b1;
          adv = 1'b1;
        end
      end
      default:
        n.st = ST_IDLE;
    endcase

    if (adv)
    begin
      if (r.svc_ch == 2'h3)
      begin
        n.tick_pend = 1'b0;
        n.st = ST_IDLE;
      end
      else
      begin
        n.svc_ch = r.svc_ch + 2'h1;
        n.st = ST_SVC;
      end
    end
    if (r.div_cnt == 8'h00)
      n.tick_pend = 1'b1;

    // commands go last so a stop beats a same-cycle start or end
    if (wr_rise)
    begin
      if (r.second)
      begin
        n.second = 1'b0;
        // a command while a fetch waits is dropped; host must space them
        if (phrase != '0 && !r.ptr_pend)
        begin
          n.ptr_pend = 1'b1;
          n.ptr_phrase = phrase;
          n.ptr_ch = command_bus_in[CH_SEL_LSB +: 2];
          n.ptr_atten = command_bus_in[3:0];
        end
      end
      else if (command_bus_in[CMD_START_BIT])
      begin
        n.second = 1'b1;
        n.first_lo = command_bus_in[6:0];
      end
      else
      begin
        n.busy = n.busy & ~command_bus_in[STOP_LSB +: 4];
        n.lo = n.lo & ~command_bus_in[STOP_LSB +: 4];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      r <= '0;
      r.wr_q <= 1'b1;
      r.div_cnt <= SAMPLE_DIV_M1;
    end
    else
      r <= n;
  end

  assign command_bus_out = r.rdat;
  assign command_bus_oe = r.oe;
  assign rom_address_out = r.rom_addr;
  assign voice_sample_out = r.mix;
  assign channel_busy = r.busy;
endmodule

// File: hdl/apc_voice.sv
// shared constants and the per-channel adpcm decoder with level control
`timescale 1ns/1ps
package apc_pkg;
  localparam int CLK_NS = 10;
  localparam int REF_CLK_HZ = 1088000;
  localparam int REF_RATE_HZ = 8000;
  localparam int SAMPLE_DIV = REF_CLK_HZ / REF_RATE_HZ;
  localparam logic [7:0] SAMPLE_DIV_M1 = 8'(SAMPLE_DIV - 1);
  localparam int ROM_AD_BASE_CYC = 5;
  localparam int ROM_AD_EXTRA_NS = 90;
  localparam int ROM_WAIT_CYC = ROM_AD_BASE_CYC + (ROM_AD_EXTRA_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] ROM_WAIT = 4'(ROM_WAIT_CYC);
  localparam int ADDR_W = 24;
  localparam int PHRASE_W = 9;
  localparam int ENTRY_SHIFT = 3;
  localparam logic [2:0] PTR_LAST_IDX = 3'h5;
  localparam int CMD_START_BIT = 7;
  localparam int EXT_LSB = 6;
  localparam int CH_SEL_LSB = 4;
  localparam int STOP_LSB = 3;
  localparam logic [3:0] ATTEN_MAX = 4'h8;
  localparam logic [11:0] MIX_OFFSET = 12'h800;
  localparam logic [11:0] STEP_BASE = 12'h010;
  localparam logic [3:0] IDX_MAX = 4'hF;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SVC = 2'b01,
    ST_FETCH = 2'b11,
    ST_PTR = 2'b10
  } apc_state_t;

  // gain in 1/256 units, roughly 3 dB per step
  function automatic logic [8:0] apc_atten_gain(input logic [3:0] a);
    case (a)
      4'h0: apc_atten_gain = 9'h100;
      4'h1: apc_atten_gain = 9'h0B1;
      4'h2: apc_atten_gain = 9'h080;
      4'h3: apc_atten_gain = 9'h05A;
      4'h4: apc_atten_gain = 9'h040;
      4'h5: apc_atten_gain = 9'h030;
      4'h6: apc_atten_gain = 9'h020;
      4'h7: apc_atten_gain = 9'h018;
      default: apc_atten_gain = 9'h010;
    endcase
  endfunction

  function automatic logic [11:0] apc_step_size(input logic [3:0] idx);
    logic [11:0] b;
    b = STEP_BASE << idx[3:1];
    apc_step_size = idx[0] ? b + (b >> 1) : b;
  endfunction
endpackage

module apc_voice
  import apc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic clear,
  input wire logic step,
  input wire logic [3:0] nibble,
  input wire logic [3:0] atten,
  output logic [11:0] sample_out
);
  typedef struct packed {
    logic [11:0] pred;
    logic [3:0] idx;
    logic [11:0] out;
  } apc_voice_st_t;

  apc_voice_st_t v_r;
  apc_voice_st_t v_nxt;

  always_comb
  begin
    logic [16:0] diff;
    logic signed [13:0] sum;
    logic signed [21:0] prod;
    diff = 17'((17'(apc_step_size(v_r.idx)) * 17'({nibble[2:0], 1'b1})) >> 3);
    sum = 14'sh0;
    prod = $signed(v_r.pred) * $signed({1'b0, apc_atten_gain(atten)});
    v_nxt = v_r;
    v_nxt.out = prod[19:8];
    if (clear)
    begin
      v_nxt.pred = 12'h000;
      v_nxt.idx = 4'h0;
    end
    else if (step)
    begin
      // sign-magnitude 4-bit code
      if (nibble[3])
        sum = $signed({{2{v_r.pred[11]}}, v_r.pred}) - $signed({1'b0, diff[12:0]});
      else
        sum = $signed({{2{v_r.pred[11]}}, v_r.pred}) + $signed({1'b0, diff[12:0]});
      if (sum > 14'sh07FF)
        v_nxt.pred = 12'h7FF;
      else if (sum < -14'sh0800)
        v_nxt.pred = 12'h800;
      else
        v_nxt.pred = sum[11:0];
      if (nibble[2])
        v_nxt.idx = (v_r.idx > IDX_MAX - 4'h2) ? IDX_MAX : v_r.idx + 4'h2;
      else
        v_nxt.idx = (v_r.idx == 4'h0) ? 4'h0 : v_r.idx - 4'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      v_r <= '0;
    else
      v_r <= v_nxt;
  end

  assign sample_out = v_r.out;
endmodule

// File: testbench/apc_properties.sv
// port-level checker for the command port
`timescale 1ns/1ps
module apc_props
  import apc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] command_bus_in,
  input wire logic [3:0] command_bus_out,
  input wire logic [3:0] command_bus_oe,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic chip_select_n,
  input wire logic [ADDR_W-1:0] rom_address_out,
  input wire logic [7:0] rom_data_in,
  input wire logic [11:0] voice_sample_out,
  input wire logic [3:0] channel_busy
);
  logic wr_r;
  logic sec_r;
  logic [6:0] b1_r;
  logic [ADDR_W-1:0] ptr_r;
  logic take;
  logic rd_on;
  assign take = nrst && write_strobe_n && !wr_r && !chip_select_n;
  assign rd_on = !chip_select_n && !read_strobe_n;
  // shadow of the byte sequencer, so stop and phrase bytes can be told apart
  always_ff @(posedge clk)
  begin
    wr_r <= nrst ? write_strobe_n : 1'b1;
    sec_r <= nrst && (take ? !sec_r && command_bus_in[7] : sec_r);
    if (take && !sec_r)
      b1_r <= command_bus_in[6:0];
    if (take && sec_r)
      ptr_r <= {12'h000, command_bus_in[7:6], b1_r, 3'h0};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_read_drive: assert property (rd_on |=> command_bus_oe == 4'hF)
    else $error("bus not driven during read");
  a_read_flags: assert property (rd_on |=> command_bus_out == $past(channel_busy))
    else $error("read flags differ from busy");
  a_oe_whole: assert property (command_bus_oe != 4'h0 |-> command_bus_oe == 4'hF)
    else $error("partial bus drive");
  a_bus_release: assert property (!rd_on |=> command_bus_oe == 4'h0)
    else $error("bus driven outside read");
  a_reset_idle: assert property (disable iff (1'b0) !nrst |=>
    channel_busy == 4'h0 && command_bus_oe == 4'h0 && rom_address_out == '0)
    else $error("activity during reset");
  a_stop_clear: assert property (take && !sec_r && !command_bus_in[7] |->
    ##2 (channel_busy & $past(command_bus_in[6:3], 2)) == 4'h0)
    else $error("stopped channel still busy");
  a_ptr_fetch: assert property (take && sec_r && {command_bus_in[7:6], b1_r} != 9'h0
    |-> ##[1:400] rom_address_out == ptr_r)
    else $error("pointer entry not addressed");
  a_no_early: assert property (take && !sec_r && command_bus_in[7] |=>
    ((channel_busy & ~$past(channel_busy)) == 4'h0) [*3])
    else $error("busy before second byte");
  c_phrase: cover property (take && sec_r);
  c_read: cover property (rd_on ##1 command_bus_out != 4'h0);
  c_end: cover property ($fell(channel_busy[1]));
endmodule
bind apc_command_port apc_props u_props (.clk(clk), .nrst(nrst),
  .command_bus_in(command_bus_in), .command_bus_out(command_bus_out),
  .command_bus_oe(command_bus_oe), .write_strobe_n(write_strobe_n),
  .read_strobe_n(read_strobe_n), .chip_select_n(chip_select_n),
  .rom_address_out(rom_address_out), .rom_data_in(rom_data_in),
  .voice_sample_out(voice_sample_out), .channel_busy(channel_busy));

// File: testbench/apc_host.sv
// host model: byte writes and busy reads on the command port
`timescale 1ns/1ps
module apc_host
(
  input wire logic clk,
  input wire logic [3:0] bus_low,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic [7:0] data
);
  initial
  begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    data = 8'h00;
  end
  // sel low leaves chip select high, to show an ignored write
  task automatic put(input logic [7:0] d, input logic sel);
    @(posedge clk);
    cs_n <= !sel;
    data <= d;
    wr_n <= 1'b0;
    @(posedge clk);
    wr_n <= 1'b1;
    @(posedge clk);
    cs_n <= 1'b1;
    data <= ~d; // released bus never keeps the old byte
  endtask
  task automatic get(output logic [3:0] v);
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    v = bus_low;
    @(posedge clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
  endtask
endmodule

// File: testbench/testbench.sv
// self-checking bench: host model, voice rom and the command port
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin err_count++; \
  $display("BAD %s exp %0h got %0h", n, e, a); end end
module testbench
  import apc_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cs_n, wr_n, rd_n;
  logic [7:0] hdata, bus, rom_d;
  logic [3:0] out, oe, busy, v;
  logic [ADDR_W-1:0] addr;
  logic [11:0] smp;
  int err_count = 0;
  int checks = 0;
  always #5 clk = ~clk;
  assign bus = {hdata[7:4], (oe & out) | (~oe & hdata[3:0])};
  // entry p points at 16 data bytes from 0x1000 + 32p
  function automatic logic [7:0] rom_f(input logic [23:0] a);
    logic [23:0] w;
    w = 24'h001000 + {10'h000, a[11:3], 5'h00} + ((a[2:0] < 3'h3) ? 24'h0 : 24'h00000F);
    case (a[2:0])
      3'h0, 3'h3: rom_f = w[23:16];
      3'h1, 3'h4: rom_f = w[15:8];
      3'h2, 3'h5: rom_f = w[7:0];
      default: rom_f = 8'hFF;
    endcase
    if (a >= 24'h001000)
      rom_f = a[7:0] ^ 8'h5A;
  endfunction
  assign rom_d = rom_f(addr);
  apc_host host_u (.clk(clk), .bus_low(bus[3:0]), .cs_n(cs_n), .wr_n(wr_n),
    .rd_n(rd_n), .data(hdata));
  apc_command_port dut_u (.clk(clk), .nrst(nrst), .command_bus_in(bus),
    .command_bus_out(out), .command_bus_oe(oe), .write_strobe_n(wr_n),
    .read_strobe_n(rd_n), .chip_select_n(cs_n), .rom_address_out(addr),
    .rom_data_in(rom_d), .voice_sample_out(smp), .channel_busy(busy));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // poll a settled value; running out of cycles ends the run
  task automatic wait_for(input logic [23:0] a, input int ch, input int lim);
    int n;
    n = 0;
    while ((ch < 0 ? addr !== a : busy[ch] !== a[0]) && n < lim)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == lim)
    begin
      err_count++;
      $display("BAD wait exp %0h got timeout", a);
      print_verdict();
    end
  endtask
  task automatic start(input logic [8:0] p, input logic [1:0] ch, input logic [3:0] at);
    host_u.put({1'b1, p[6:0]}, 1'b1);
    host_u.put({p[8:7], ch, at}, 1'b1);
    for (int i = 0; i < 6; i++)
      wait_for({12'h000, p, 3'h0} + 24'(i), -1, 400);
    wait_for(24'h1, int'(ch), 400);
    wait_for(24'h001000 + {10'h000, p, 5'h00}, -1, 400);
  endtask
  task automatic t_one();
    start(9'h001, 2'h1, 4'h2);
    host_u.get(v);
    `CHK("busy read", 4'h2, v)
    wait_for(24'h0, 1, 6000);
    host_u.get(v);
    `CHK("busy read end", 4'h0, v)
    $display("test one_phrase done");
  endtask
  task automatic t_two();
    start(9'h1FF, 2'h3, 4'h8);
    start(9'h003, 2'h0, 4'h0);
    host_u.get(v);
    `CHK("busy read", 4'h9, v)
    // drive falls one edge after the strobes rise
    @(posedge clk);
    #1;
    `CHK("oe after read", 4'h0, oe)
    host_u.put(8'h48, 1'b1);
    repeat (3) @(posedge clk);
    #1;
    `CHK("busy after stop", 4'h0, busy)
    $display("test two_and_stop done");
  endtask
  task automatic t_mid();
    start(9'h080, 2'h2, 4'h5);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("busy in reset", 4'h0, busy)
    `CHK("addr in reset", 24'h0, addr)
    @(posedge clk);
    nrst <= 1'b1;
    $display("test reset_in_play done");
  endtask
  task automatic t_refuse();
    host_u.put(8'h80, 1'b1);
    host_u.put(8'h00, 1'b1);
    host_u.put(8'h81, 1'b0);
    host_u.put(8'h10, 1'b0);
    repeat (300) @(posedge clk);
    #1;
    `CHK("busy refused", 4'h0, busy)
    `CHK("addr refused", 24'h0, addr)
    `CHK("silence", MIX_OFFSET, smp)
    $display("test refused done");
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("busy", 4'h0, busy)
    `CHK("oe", 4'h0, oe)
    `CHK("addr", 24'h0, addr)
    `CHK("sample", 12'h000, smp)
    $display("test reset done");
    t_one();
    t_two();
    t_mid();
    t_refuse();
    print_verdict();
  end
endmodule
